// ---- design/lcs_pkg.sv ----
// ==========================================================
// shared constants of the cascade sync block
package lcs_pkg;
  // system clock rate and internal frame clock rate
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int INT_FCLK_HZ = 1850;
  // half period of the internal frame clock in system cycles
  localparam int INT_HALF_DIV = SYS_CLK_HZ / (2 * INT_FCLK_HZ);
  // frame clock periods in one frame
  localparam logic [4:0] FRAME_TICKS = 5'h18;
  // upper six bits of both bus target addresses (0111 00x)
  localparam logic [5:0] TGT_ADDR_HI = 6'h1c;
  // read/write bit value for a write
  localparam logic RW_WRITE = 1'h0;
  // tick count loaded on realign: the sync edge is seen one frame tick late
  localparam logic [4:0] REALIGN_CNT = 5'h01;
  // last phase index per drive mode: static, 1:2, 1:3, 1:4
  localparam logic [1:0] MODE_STATIC = 2'h0;
  localparam logic [1:0] MODE_MUX2 = 2'h1;
  localparam logic [1:0] MODE_MUX3 = 2'h2;
  localparam logic [1:0] MODE_MUX4 = 2'h3;
  // reset values
  localparam logic [1:0] PHASE_RST = 2'h0;
  localparam logic [4:0] CNT_RST = 5'h00;
endpackage

// ---- design/lcs_sync_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// carries a pin level into the synchroniser and back out
interface lcs_sync_if #(parameter int W = 1);
  logic [W-1:0] async_lvl;
  logic [W-1:0] sync_lvl;
  modport sync_side (input async_lvl, output sync_lvl);
  modport user_side (output async_lvl, input sync_lvl);
endinterface
`default_nettype wire

// ---- design/lcs_sync2.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// two flip-flop synchroniser, first stage read only by the second
module lcs_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  lcs_sync_if.sync_side lnk
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // plain register pair, no logic between the stages
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= lnk.async_lvl;
      sync_ff <= meta_ff;
    end
  end

  assign lnk.sync_lvl = sync_ff;
endmodule
`default_nettype wire

// ---- design/lcs_cascade.sv ----
// How it works
// - up to sixteen drivers share one bus, told apart by the select bit and three subaddress straps.
// - the device index is the strap subaddress plus eight when the select bit is set.
// - after power-on reset every driver starts its backplane frame at phase zero, so all start in step.
// - the sync line is only ever pulled low, a pull-up returns it high, making a wired-AND.
// - the sync line is pulled low through the whole last active backplane phase and released otherwise.
// - a low sync line seen by a monitoring device moves its phase counter into the last phase.
// - synchronised drivers keep identical backplane phases so one device can drive all backplanes.
// - one controller per cascade, and all devices run on the same frame clock.
// - with the oscillator strap high the frame clock is taken from the clock pin as an input.
// - only the target address whose low bit equals the select strap is acknowledged.
// - a read request is never acknowledged.
// - data bytes are acknowledged only when the tracked subaddress equals the straps.
`timescale 1ns/100ps
`default_nettype none
module lcs_cascade #(
  // internal frame clock half period in system cycles
  parameter int INT_HALF_DIV = lcs_pkg::INT_HALF_DIV
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic target_addr_select_i,
  input wire logic [2:0] hw_subaddress_straps_i,
  input wire logic osc_enable_strap_i,
  input wire logic [1:0] mux_mode_i,
  input wire logic [7:0] addr_byte_i,
  input wire logic addr_valid_i,
  input wire logic [2:0] data_subaddr_i,
  input wire logic data_valid_i,
  input wire logic sync_pin_i,
  output logic sync_pin_o,
  output logic sync_pin_oe_o,
  input wire logic clk_pin_i,
  output logic clk_pin_o,
  output logic clk_pin_oe_o,
  output logic [3:0] device_index_o,
  output logic addr_ack_o,
  output logic data_ack_o,
  output logic [3:0] backplane_outputs_o,
  output logic frame_tick_o
);
  // ==========================================================
  // pin synchronisers
  lcs_sync_if #(.W(5)) strap_if ();
  lcs_sync_if #(.W(2)) line_if ();
  assign strap_if.async_lvl = {osc_enable_strap_i, target_addr_select_i, hw_subaddress_straps_i};
  assign line_if.async_lvl = {sync_pin_i, clk_pin_i};

  lcs_sync2 #(.W(5), .RST_VAL(5'h00)) u_strap_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .lnk(strap_if)
  );
  // lines idle high thanks to their pull-ups
  lcs_sync2 #(.W(2), .RST_VAL(2'h3)) u_line_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .lnk(line_if)
  );

  logic ext_clk_sel;
  logic sel_s;
  logic [2:0] sub_s;
  logic sync_s;
  logic clkpin_s;
  assign ext_clk_sel = strap_if.sync_lvl[4];
  assign sel_s = strap_if.sync_lvl[3];
  assign sub_s = strap_if.sync_lvl[2:0];
  assign sync_s = line_if.sync_lvl[1];
  assign clkpin_s = line_if.sync_lvl[0];

  // ==========================================================
  // device index and bus address matching
  logic [3:0] nxt_index;
  always_comb begin
    nxt_index = {sel_s, sub_s};
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      device_index_o <= 4'h0;
    end else begin
      device_index_o <= nxt_index;
    end
  end

  assign addr_ack_o = addr_valid_i && (addr_byte_i[7:1] == {lcs_pkg::TGT_ADDR_HI, sel_s})
                      && (addr_byte_i[0] == lcs_pkg::RW_WRITE);
  // subaddress match on the straps only; the select bit is not compared here
  assign data_ack_o = data_valid_i && (data_subaddr_i == sub_s);

  // ==========================================================
  // frame clock: internal divider or clock pin
  logic [15:0] div_ff;
  logic [15:0] nxt_div;
  logic fclk_ff;
  logic nxt_fclk;
  logic pin_prev_ff;
  logic int_rise;
  logic frame_tick;

  always_comb begin
    nxt_div = div_ff + 16'h0001;
    nxt_fclk = fclk_ff;
    int_rise = 1'b0;
    if (div_ff >= 16'(INT_HALF_DIV - 1)) begin
      nxt_div = 16'h0000;
      nxt_fclk = !fclk_ff;
      int_rise = !fclk_ff;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_ff <= 16'h0000;
      fclk_ff <= 1'b0;
      pin_prev_ff <= 1'b1;
    end else begin
      div_ff <= nxt_div;
      fclk_ff <= nxt_fclk;
      pin_prev_ff <= clkpin_s;
    end
  end

  // external clock taken from the pin, pin driver off
  assign frame_tick = ext_clk_sel ? (clkpin_s && !pin_prev_ff) : int_rise;
  assign clk_pin_oe_o = !ext_clk_sel;
  assign clk_pin_o = fclk_ff;
  assign frame_tick_o = frame_tick;

  // ==========================================================
  // backplane phase counter and sync line
  logic [1:0] ph_ff;
  logic [1:0] nxt_ph;
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic drive_ff;
  logic nxt_drive;
  logic [3:0] bp_ff;
  logic [3:0] nxt_bp;
  logic [1:0] last_ph;
  logic [4:0] ph_len;
  logic realign;
  logic [1:0] own_hist_ff;
  logic [1:0] nxt_own_hist;

  // phase length is the frame split evenly across the backplanes
  always_comb begin
    last_ph = mux_mode_i;
    case (mux_mode_i)
      lcs_pkg::MODE_STATIC: ph_len = lcs_pkg::FRAME_TICKS;
      lcs_pkg::MODE_MUX2: ph_len = 5'(lcs_pkg::FRAME_TICKS / 2);
      lcs_pkg::MODE_MUX3: ph_len = 5'(lcs_pkg::FRAME_TICKS / 3);
      default: ph_len = 5'(lcs_pkg::FRAME_TICKS / 4);
    endcase
  end

  // own pull-down is not taken as a request
  // the synchroniser still shows our own low for two cycles after release, so mask those too
  assign realign = frame_tick && !drive_ff && (own_hist_ff == 2'h0) && !sync_s;

  always_comb begin
    nxt_ph = ph_ff;
    nxt_cnt = cnt_ff;
    nxt_own_hist = {own_hist_ff[0], drive_ff};
    if (realign) begin
      nxt_ph = last_ph;
      nxt_cnt = lcs_pkg::REALIGN_CNT;
    end else if (frame_tick) begin
      if (cnt_ff >= ph_len - 5'h01) begin
        nxt_cnt = 5'h00;
        nxt_ph = (ph_ff >= last_ph) ? 2'h0 : ph_ff + 2'h1;
      end else begin
        nxt_cnt = cnt_ff + 5'h01;
      end
    end
    // pull low for the whole last phase
    nxt_drive = (nxt_ph == last_ph);
    // backplane select follows the shared phase
    nxt_bp = 4'h1 << nxt_ph;
  end

  // every device leaves reset at phase zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_ff <= lcs_pkg::PHASE_RST;
      cnt_ff <= lcs_pkg::CNT_RST;
      drive_ff <= 1'b0;
      bp_ff <= 4'h1;
      own_hist_ff <= 2'h0;
    end else begin
      ph_ff <= nxt_ph;
      cnt_ff <= nxt_cnt;
      drive_ff <= nxt_drive;
      bp_ff <= nxt_bp;
      own_hist_ff <= nxt_own_hist;
    end
  end

  // open drain: data always low, only the enable moves
  assign sync_pin_o = 1'b0;
  assign sync_pin_oe_o = drive_ff;
  assign backplane_outputs_o = bp_ff;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_INDEX: assert property (##1 device_index_o == {$past(sel_s), $past(sub_s)})
    else $error("device index does not follow straps");
  AST_ADDR_ACK: assert property (addr_valid_i && addr_byte_i[7:2] == lcs_pkg::TGT_ADDR_HI
      && addr_byte_i[0] == 1'b0 |-> addr_ack_o == (addr_byte_i[1] == sel_s))
    else $error("address ack disagrees with select strap");
  AST_READ_NACK: assert property (addr_byte_i[0] |-> !addr_ack_o)
    else $error("read request acknowledged");
  AST_DATA_ACK: assert property (data_valid_i |-> data_ack_o == (data_subaddr_i == sub_s))
    else $error("data ack disagrees with subaddress");
  // drive is decided with the previous cycle's mode, so a mode change shows one cycle late
  AST_SYNC_PHASE: assert property (sync_pin_oe_o |-> ph_ff == $past(last_ph) && sync_pin_o == 1'b0)
    else $error("sync driven outside last phase");
  AST_REALIGN: assert property (realign |=> ph_ff == $past(last_ph) && cnt_ff == 5'h01
      && sync_pin_oe_o)
    else $error("no realign after sync seen");
  AST_NO_SELF: assert property (frame_tick && drive_ff && cnt_ff < ph_len - 5'h01
      |=> cnt_ff == $past(cnt_ff) + 5'h01 && ph_ff == $past(ph_ff))
    else $error("own sync pull-down caused realign");
  AST_HOLD: assert property (!frame_tick |=> $stable(ph_ff) && $stable(cnt_ff))
    else $error("phase moved without frame tick");
  AST_CLK_DIR: assert property (ext_clk_sel |-> !clk_pin_oe_o)
    else $error("clock pin driven with external clock");
  AST_BP: assert property (##1 backplane_outputs_o == (4'h1 << ph_ff))
    else $error("backplane select off phase");

  COV_REALIGN: cover property (realign);
  COV_FRAME_WRAP: cover property (frame_tick && ph_ff == last_ph ##1 ph_ff == 2'h0);
  COV_ADDR_ACK: cover property (addr_ack_o);
  COV_DATA_ACK: cover property (data_ack_o);
endmodule
`default_nettype wire

// ---- tb/lcs_peer.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// neighbour driver: external frame clock source and sync pull-down
module lcs_peer (
  input wire logic clk_i,
  input wire logic ext_en_i,
  input wire logic pull_i,
  output logic ext_clk_o,
  output logic pull_oe_o
);
  logic [2:0] div_ff = 3'h0;
  initial ext_clk_o = 1'b0;
  // frame clock with a period of 10 cycles
  // clock stands still low while the source is disabled
  always @(posedge clk_i) begin
    if (!ext_en_i) begin
      div_ff <= 3'h0;
      ext_clk_o <= 1'b0;
    end else if (div_ff == 3'h4) begin
      div_ff <= 3'h0;
      ext_clk_o <= !ext_clk_o;
    end else begin
      div_ff <= div_ff + 3'h1;
    end
  end
  assign pull_oe_o = pull_i; // never drives the wire high
endmodule
`default_nettype wire

// ---- tb/lcs_cascade_test.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// cascade sync bench
module lcs_cascade_test;
  logic clk = 1'b0, rst_n = 1'b0, sel = 1'b0, osc = 1'b0, av = 1'b0, dv = 1'b0, pull = 1'b0;
  logic [2:0] straps = 3'h0, dsub = 3'h0;
  logic [1:0] mode = 2'h3;
  logic [7:0] abyte = 8'h00;
  logic s_oe, s_o, c_o, c_oe, aack, dack, tick, ext_clk, peer_oe, c_prev;
  logic [3:0] idx, bp;
  int err_total = 0, compares = 0, n_hi, n_lo, x;
  // wired-AND with pull-up; clock pin from whichever side drives it
  wire logic sync_w = !((s_oe && !s_o) || peer_oe);
  wire logic clkpin_w = c_oe ? c_o : ext_clk;
  always #5 clk = !clk;
  lcs_cascade #(.INT_HALF_DIV(4)) uut (.clk_i(clk), .rst_n_i(rst_n), .target_addr_select_i(sel),
    .hw_subaddress_straps_i(straps), .osc_enable_strap_i(osc), .mux_mode_i(mode), .addr_byte_i(abyte),
    .addr_valid_i(av), .data_subaddr_i(dsub), .data_valid_i(dv), .sync_pin_i(sync_w), .sync_pin_o(s_o),
    .sync_pin_oe_o(s_oe), .clk_pin_i(clkpin_w), .clk_pin_o(c_o), .clk_pin_oe_o(c_oe),
    .device_index_o(idx), .addr_ack_o(aack), .data_ack_o(dack), .backplane_outputs_o(bp),
    .frame_tick_o(tick));
  lcs_peer peer (.clk_i(clk), .ext_en_i(osc), .pull_i(pull), .ext_clk_o(ext_clk), .pull_oe_o(peer_oe));
  // ==========================================================
  // shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // counts frame ticks while oe holds v; bounded so a stuck oe is caught
  task automatic count_while(input logic v, output int n);
    int g;
    n = 0;
    g = 0;
    while (s_oe === v && g < 1000) begin
      if (tick === 1'b1) n++;
      cyc(1);
      g++;
    end
    if (g == 1000) check(8'h00, 8'h01);
  endtask
  task automatic frame_count();
    count_while(1'b1, x);
    count_while(1'b0, x);
    count_while(1'b1, n_hi);
    count_while(1'b0, n_lo);
  endtask
  task automatic wrap_up();
    $display("compares=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog: the tests need a few thousand cycles
  initial begin
    #100000;
    err_total++;
    wrap_up();
  end
  // ==========================================================
  // tests
  initial begin
    cyc(12);
    check({s_oe, c_oe, 2'h0, bp}, 8'h41); // reset state
    @(posedge clk);
    rst_n <= 1'b1;
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      {sel, straps} <= i[3:0];
      dsub <= i[2:0];
      {av, dv} <= 2'h3;
      abyte <= {6'h1c, i[3], 1'b0};
      cyc(4);
      check({4'h0, idx}, i[7:0]); // index
      check({aack, dack}, 8'h03); // matching acks
      @(posedge clk);
      abyte <= {6'h1c, !i[3], 1'b0};
      dsub <= i[2:0] ^ 3'h1;
      cyc(1);
      check({aack, dack}, 8'h00); // other select, other subaddress
      @(posedge clk);
      abyte <= {6'h1c, i[3], 1'b1};
      cyc(1);
      check({7'h0, aack}, 8'h00); // read refused
    end
    $display("address test done");
    for (int m = 1; m < 4; m++) begin
      @(posedge clk);
      mode <= m[1:0];
      #1;
      frame_count();
      frame_count();
      check({4'h0, bp}, 8'h01 << m); // last phase
      check(8'(n_hi), 8'(24 / (m + 1))); // oe through last phase
      check(8'(n_hi + n_lo), 8'h18); // frame length
      check({7'h0, s_o}, 8'h00); // open drain
    end
    $display("frame test done");
    // mode 3 now; pull the line while this device is in phase 0
    count_while(1'b1, n_hi);
    @(posedge clk);
    pull <= 1'b1;
    #1;
    count_while(1'b0, n_lo);
    check({4'h0, bp}, 8'h08); // realign to last phase
    count_while(1'b1, n_hi);
    @(posedge clk);
    pull <= 1'b0;
    check(8'(n_lo), 8'h01); // first tick
    check(8'(n_hi), 8'h05); // own phase pull ignored
    $display("realign test done");
    @(posedge clk);
    mode <= 2'h0;
    cyc(300);
    check({s_oe, 3'h0, bp}, 8'h81); // static mode oe held
    // internal clock on the pin: period 2 * INT_HALF_DIV = 8 cycles
    c_prev = c_o;
    n_lo = 0;
    repeat (80) begin
      cyc(1);
      if (c_o === 1'b1 && c_prev === 1'b0) n_lo++;
      c_prev = c_o;
    end
    check(8'(n_lo), 8'h0a); // controller supplies the frame clock
    @(posedge clk);
    osc <= 1'b1;
    cyc(5);
    check({7'h0, c_oe}, 8'h00); // clock pin is input
    x = 0;
    while (ext_clk !== 1'b1 && x < 50) begin
      cyc(1);
      x++;
    end
    n_hi = 0;
    repeat (100) begin
      cyc(1);
      if (tick === 1'b1) n_hi++;
    end
    check(8'(n_hi), 8'h0a); // ticks follow external clock
    $display("external clock test done");
    wrap_up();
  end
endmodule
`default_nettype wire
